//--- bench/far_side_model.sv
// far side model: modem handshake lines and host i/o address bus
`timescale 1ns/1ps
module far_side_model
    import uart_host_pkg::*;
(
    input  wire logic       aclk,
    input  wire modem_in_t  modem_req,
    input  wire logic [9:0] addr_req,
    input  wire logic       aen_req_n,
    output modem_in_t       modem_in,
    output logic [9:0]      host_addr,
    output logic            address_enable_n
);
    logic [9:0] addr_q = 10'h155;
    logic       aen_q  = 1'b1;
    // modem lines low mean ready, carrier or ring present
    assign modem_in = modem_req;
    assign host_addr = addr_q;
    assign address_enable_n = aen_q;
    // idle bus: address flips every cycle so no stale match survives
    always_ff @(posedge aclk) begin
        aen_q <= aen_req_n;
        if (!aen_req_n) begin
            addr_q <= addr_req;
        end else begin
            addr_q <= ~addr_q;
        end
    end
endmodule : far_side_model

//--- bench/tb.sv
// self-checking bench for the modem control and host decode block
`timescale 1ns/1ps
module tb
    import uart_host_pkg::*;
;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, master_reset = 0, host_mode_select = 0;
    logic port_select1 = 0, port_select2 = 0, ps3_in = 0, aen_req_n = 1;
    logic rx_error = 0, rx_data_avail = 0, tx_empty = 0, tx_char_done = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [5:0] rx_fifo_level = 0, rx_trigger_level = 6'h3F;
    logic [9:0] addr_req = 0, host_addr;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, ps3_out, ps3_oe;
    logic rts_n, dtr_n, user_out1_n, lpt1_decode_n, lpt2_decode_n;
    logic com_select, tx_halt, tx_enable, rx_enable, address_enable_n;
    modem_in_t modem_req = 4'hF, modem_in;
    irq_pins_t irq;
    logic [33:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] seed;
    int error_cnt = 0, check_count = 0, ln;
    logic [7:0] mcr_tab[5] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h00};
    logic [9:0] com_tab[4] = '{COM1_BASE, COM2_BASE, COM3_BASE, COM4_BASE};
    logic [9:0] lpt_tab[2] = '{LPT1_BASE, LPT2_BASE};
    modem_in_t msr_tab[4] = '{4'h0, 4'hF, 4'hE, 4'h7};
    logic [3:0] dlt_tab[4] = '{4'hB, 4'hF, 4'h1, 4'h1};

    uart_modem_host dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .master_reset, .host_mode_select, .host_addr, .address_enable_n,
        .port_select1, .port_select2, .ps3_in, .ps3_out, .ps3_oe,
        .modem_in, .rts_n, .dtr_n, .user_out1_n, .irq, .lpt1_decode_n,
        .lpt2_decode_n, .com_select, .rx_error, .rx_data_avail, .tx_empty,
        .tx_char_done, .rx_fifo_level, .rx_trigger_level, .tx_halt,
        .tx_enable, .rx_enable);
    far_side_model far_u (.aclk, .modem_req, .addr_req, .aen_req_n,
        .modem_in, .host_addr, .address_enable_n);

    initial begin
        forever #20 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [33:0] e,
                       input logic [33:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic hang(input string nm);
        chk(nm, 1, 0);
        end_sim();
    endtask : hang
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    // checks land mid-cycle so outputs have settled
    task automatic look(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : look
    // write: aw and w offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        logic aw, w, b;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            aw = awvalid && (awready === 1'b1);
            w = wvalid && (wready === 1'b1);
            b = (bvalid === 1'b1);
            if (b) chk("bresp", RESP_OKAY, bresp);
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            n++;
            if (n > 50) hang("bvalid");
        end
        bready <= 1'b0;
    endtask : wr
    // read: expectation queued, monitor compares when rvalid shows
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] r);
        int n;
        logic ar, rv;
        exp_q.push_back({r, d});
        msk_q.push_back(m);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        rv = 1'b0;
        while (!rv) begin
            @(negedge aclk);
            ar = arvalid && (arready === 1'b1);
            rv = (rvalid === 1'b1);
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            n++;
            if (n > 50) hang("rvalid");
        end
        rready <= 1'b0;
    endtask : rd
    task automatic pulse_done;
        @(posedge aclk);
        tx_char_done <= 1'b1;
        @(posedge aclk);
        tx_char_done <= 1'b0;
    endtask : pulse_done
    ////////////////////////////////////////////////////////////////////////
    // oldest note is taken when the read answer stands
    always @(negedge aclk) begin
        if (rvalid === 1'b1 && rready) begin
            if (exp_q.size() == 0) begin
                chk("read_note", 1, 0);
            end else begin
                chk("read", exp_q[0] & {2'h3, msk_q[0]},
                    {rresp, rdata} & {2'h3, msk_q[0]});
                void'(exp_q.pop_front());
                void'(msk_q.pop_front());
            end
        end
    end

    initial begin
        seed = 32'h56E0;
        tick(8);
        aresetn <= 1'b1;
        look(3);
        chk("rts_n", 1, rts_n);
        chk("dtr_n", 1, dtr_n);
        chk("irq_oe", 0, irq.oe);
        rd(IER_OFFSET, IER_RESET, 32'hFF, RESP_OKAY);
        rd(EFR_OFFSET, EFR_RESET, 32'hFF, RESP_OKAY);
        rd(STATUS_OFFSET, {FIFO_DEPTH, 8'h0}, 32'hFF01, RESP_OKAY);
        rd(8'h0C, 0, 32'hFFFFFFFF, RESP_SLVERR);
        foreach (mcr_tab[k]) begin
            wr(MCR_OFFSET, mcr_tab[k]);
            look(2);
            chk("dtr_n", !mcr_tab[k][0], dtr_n);
            chk("rts_n", !mcr_tab[k][1], rts_n);
            chk("out1_n", !mcr_tab[k][2], user_out1_n);
            rd(MCR_OFFSET, mcr_tab[k], 32'hFF, RESP_OKAY);
        end
        // direct mode: decode each serial range, route to its pin
        wr(IER_OFFSET, 8'h01);
        rx_data_avail <= 1'b1;
        look(2);
        chk("irq_oe", 0, irq.oe);
        wr(MCR_OFFSET, 8'h08);
        for (int i = 0; i < 5; i++) begin
            tick(1);
            {ps3_in, port_select2, port_select1} <= (i == 4) ? 4 : i;
            addr_req <= com_tab[i % 4] + 10'($random(seed) & 7);
            aen_req_n <= 1'b0;
            look(5);
            ln = (i == 4) ? 2 : i % 2;
            chk("com_select", 1, com_select);
            chk("irq_line_oe", 1, irq.oe[ln]);
            chk("irq_line", 1, irq.out[ln]);
            tick(1);
            aen_req_n <= 1'b1;
            look(5);
            chk("com_select", 0, com_select);
        end
        foreach (lpt_tab[k]) begin
            tick(1);
            ps3_in <= 1'b0;
            addr_req <= lpt_tab[k] + 10'($random(seed) & 7);
            aen_req_n <= 1'b0;
            look(5);
            chk("lpt1_n", k != 0, lpt1_decode_n);
            chk("lpt2_n", k != 1, lpt2_decode_n);
            tick(1);
            aen_req_n <= 1'b1;
        end
        // shared line: only the primary pin, driven high when pending
        port_select1 <= 1'b1;
        wr(MCR_OFFSET, 8'h28);
        look(3);
        chk("irq_oe", 3'b001, irq.oe);
        chk("irq_out0", 1, irq.out[0]);
        tick(1);
        rx_data_avail <= 1'b0;
        look(2);
        chk("irq_oe", 0, irq.oe);
        // generic bus mode
        tick(1);
        host_mode_select <= 1'b1;
        wr(MCR_OFFSET, 8'h08);
        look(4);
        chk("ps3_oe", 1, ps3_oe);
        chk("ps3_out", 0, ps3_out);
        rd(STATUS_OFFSET, 1, 1, RESP_OKAY);
        for (int j = 0; j < 3; j++) begin
            wr(IER_OFFSET, 8'h01 << j);
            {rx_error, tx_empty, rx_data_avail} <= 3'b001 << j;
            look(2);
            chk("irq_oe", 3'b001, irq.oe);
            chk("irq_out0", 1, irq.out[0]);
            tick(1);
            {rx_error, tx_empty, rx_data_avail} <= 3'b001 << ((j + 1) % 3);
            look(2);
            chk("irq_out0", 0, irq.out[0]);
        end
        wr(MCR_OFFSET, 8'h00);
        look(2);
        chk("ps3_out", 1, ps3_out);
        wr(IER_OFFSET, 8'h08);
        foreach (msr_tab[k]) begin
            tick(1);
            modem_req <= msr_tab[k];
            look(4);
            chk("tx_enable", 1, tx_enable);
            chk("irq_modem", 1, irq.out[0]);
            rd(MSR_OFFSET, {~msr_tab[k].cd_n, ~msr_tab[k].ri_n,
                ~msr_tab[k].dsr_n, ~msr_tab[k].cts_n, dlt_tab[k]}, 32'hFF,
                RESP_OKAY);
        end
        // cts high now: halt only with auto-cts, after the character
        pulse_done();
        look(1);
        chk("tx_halt", 0, tx_halt);
        wr(EFR_OFFSET, 8'h80);
        look(2);
        chk("tx_halt", 0, tx_halt);
        pulse_done();
        look(1);
        chk("tx_halt", 1, tx_halt);
        tick(1);
        modem_req <= 4'hE;
        look(4);
        chk("tx_halt", 0, tx_halt);
        wr(MCR_OFFSET, 8'h02);
        rx_trigger_level <= 6'd8;
        rx_fifo_level <= 6'd8;
        look(2);
        chk("rts_n", 0, rts_n);
        wr(EFR_OFFSET, 8'h40);
        look(2);
        chk("rts_n", 1, rts_n);
        tick(1);
        rx_fifo_level <= 6'd7;
        look(2);
        chk("rts_n", 0, rts_n);
        wr(MCR_OFFSET, 8'h07);
        master_reset <= 1'b1;
        look(4);
        chk("dtr_n", 1, dtr_n);
        chk("out1_n", 1, user_out1_n);
        chk("txrx_en", 0, {tx_enable, rx_enable});
        tick(1);
        master_reset <= 1'b0;
        look(5);
        chk("tx_enable", 1, tx_enable);
        rd(MCR_OFFSET, MCR_RESET, 32'hFF, RESP_OKAY);
        look(3);
        end_sim();
    end
endmodule : tb

//--- inc/uart_host_pkg.sv
// constants, register map and carrier types for the modem/host decode block
package uart_host_pkg;

    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] IER_OFFSET    = 8'h04;
    localparam logic [7:0] EFR_OFFSET    = 8'h08;
    localparam logic [7:0] MCR_OFFSET    = 8'h10;
    localparam logic [7:0] MSR_OFFSET    = 8'h18;
    localparam logic [7:0] STATUS_OFFSET = 8'h1C;

    // reset values
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] EFR_RESET = 8'h00;
    localparam logic [7:0] MCR_RESET = 8'h00;

    // modem control fields
    localparam int MCR_DTR_BIT    = 0;
    localparam int MCR_RTS_BIT    = 1;
    localparam int MCR_OUT1_BIT   = 2;
    localparam int MCR_IRQEN_BIT  = 3;
    localparam int MCR_SHARED_BIT = 5;

    // enhanced feature fields
    localparam int EFR_AUTO_RTS_BIT = 6;
    localparam int EFR_AUTO_CTS_BIT = 7;

    // interrupt enable fields
    localparam int IER_RXDATA_BIT = 0;
    localparam int IER_TXEMPTY_BIT = 1;
    localparam int IER_RXERR_BIT  = 2;
    localparam int IER_MODEM_BIT  = 3;

    // modem status fields: deltas low, levels high
    localparam int MSR_CTS_BIT = 4;

    // status register fields
    localparam int STATUS_MODE_BIT = 0;
    localparam int STATUS_HIT_BIT  = 1;
    localparam logic [7:0] FIFO_DEPTH = 8'h20;

    // host i/o address ranges, compared on bits 9..3
    localparam logic [9:0] COM1_BASE = 10'h3F8;
    localparam logic [9:0] COM2_BASE = 10'h2F8;
    localparam logic [9:0] COM3_BASE = 10'h3E8;
    localparam logic [9:0] COM4_BASE = 10'h2E8;
    localparam logic [9:0] LPT1_BASE = 10'h378;
    localparam logic [9:0] LPT2_BASE = 10'h278;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // modem handshake inputs, all active low
    typedef struct packed {
        logic ri_n;
        logic cd_n;
        logic dsr_n;
        logic cts_n;
    } modem_in_t;

    // three interrupt pins: level and drive enable
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } irq_pins_t;

endpackage : uart_host_pkg

//--- rtl/uart_modem_host.sv
// modem control, host mode select, port decode and interrupt pins of a uart
// Contract
// - direct mode: primary interrupt only when control bit 3 set and source on
// - generic mode: primary interrupt is active-high push-pull unless control bit 5 set
// - control bit 5 makes primary interrupt open-source for a shared line
// - mode select low picks direct mode; high or open picks generic mode
// - select-3 pin: port select input direct, user output 2 generic
// - rts pin low while control bit 1 is one, high after reset
// - rts affects data flow only with auto-rts feature bit 6
// - dtr pin follows control bit 0 inverted, high after reset
// - user output 1 pin driven inverted from control bit 2
// - master reset high returns pin outputs and control registers to reset state; the axi slave keeps running
// - master reset disables serial transmit and receive
// - cts level readable in modem status bit 4
// - cts affects data flow only with auto-cts feature bit 7
// - dsr is status only, low means modem ready
// - compatible after reset, fifo mode gives 32-byte fifos
// - direct mode decodes the four serial port ranges and routes interrupt
// - three port-select pins choose address range and interrupt line
// - direct mode decodes both printer ranges onto dual-purpose pins
// - direct mode interrupts float until control bit 3 set
// - auto-cts halts after current character while cts high
// - auto-rts forces rts high at receive trigger level, restores below
// - shared interrupt mode keeps second and third interrupts inactive
`timescale 1ns/1ps
module uart_modem_host
    import uart_host_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        master_reset,
    input  wire logic        host_mode_select,
    input  wire logic [9:0]  host_addr,
    input  wire logic        address_enable_n,
    input  wire logic        port_select1,
    input  wire logic        port_select2,
    input  wire logic        ps3_in,
    output logic             ps3_out,
    output logic             ps3_oe,
    input  wire modem_in_t   modem_in,
    output logic             rts_n,
    output logic             dtr_n,
    output logic             user_out1_n,
    output irq_pins_t        irq,
    output logic             lpt1_decode_n,
    output logic             lpt2_decode_n,
    output logic             com_select,
    input  wire logic        rx_error,
    input  wire logic        rx_data_avail,
    input  wire logic        tx_empty,
    input  wire logic        tx_char_done,
    input  wire logic [5:0]  rx_fifo_level,
    input  wire logic [5:0]  rx_trigger_level,
    output logic             tx_halt,
    output logic             tx_enable,
    output logic             rx_enable
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage read only by second stage

    localparam int SYNC_W = 20;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;

    assign pins_raw = {master_reset, host_mode_select, host_addr,
                       address_enable_n, port_select1, port_select2, ps3_in,
                       modem_in};

    // two flops per pin; reset to idle levels (master reset low, other lines high)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= {1'b0, {(SYNC_W-1){1'b1}}};
            sync2_reg <= {1'b0, {(SYNC_W-1){1'b1}}};
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic        mr_s;
    logic        mode_s;
    logic [9:0]  addr_s;
    logic        aen_n_s;
    logic [2:0]  sel_s;
    modem_in_t   modem_s;

    assign {mr_s, mode_s, addr_s, aen_n_s, sel_s[0], sel_s[1], sel_s[2],
            modem_s} = sync2_reg;

    // master reset folds into the control reset
    logic run_n;
    assign run_n = aresetn && !mr_s;

    logic direct_mode;
    assign direct_mode = !mode_s;

    ////////////////////////////////////////////////////////////////////////
    // control registers and axi4-lite slave

    logic [7:0] ier_reg;
    logic [7:0] efr_reg;
    logic [7:0] mcr_reg;
    logic [3:0] delta_reg;
    logic       aw_held_reg;
    logic       w_held_reg;
    logic [7:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic       wstrb0_reg;
    logic       do_write;
    logic       msr_read;

    assign awready  = !aw_held_reg && !bvalid;
    assign wready   = !w_held_reg && !bvalid;
    assign arready  = !rvalid;
    assign do_write = aw_held_reg && w_held_reg && !bvalid;
    assign msr_read = arvalid && arready && (araddr == MSR_OFFSET);

    // write address and data are latched independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 8'h00;
            wstrb0_reg  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= wdata[7:0];
                wstrb0_reg <= wstrb[0];
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // write response; unmapped offsets get slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= (awaddr_reg == IER_OFFSET || awaddr_reg == EFR_OFFSET ||
                       awaddr_reg == MCR_OFFSET) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // software registers; master reset clears them too
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            ier_reg <= IER_RESET;
            efr_reg <= EFR_RESET;
            mcr_reg <= MCR_RESET;
        end else if (do_write && wstrb0_reg) begin
            if (awaddr_reg == IER_OFFSET) ier_reg <= wdata_reg;
            if (awaddr_reg == EFR_OFFSET) efr_reg <= wdata_reg;
            if (awaddr_reg == MCR_OFFSET) mcr_reg <= wdata_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modem status: levels and sticky change flags

    logic [3:0] level_now;
    logic [3:0] level_prev_reg;
    logic [3:0] delta_set;

    // msr order high nibble: cd, ri, dsr, cts (active high inside)
    assign level_now = ~{modem_s.cd_n, modem_s.ri_n, modem_s.dsr_n,
                         modem_s.cts_n};
    // ring delta only on trailing edge of ring, like the classic part
    assign delta_set = {level_now[3] ^ level_prev_reg[3],
                        level_prev_reg[2] && !level_now[2],
                        level_now[1:0] ^ level_prev_reg[1:0]};

    // reading msr clears flags, but a change in the same cycle survives
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            level_prev_reg <= 4'h0;
            delta_reg      <= 4'h0;
        end else begin
            level_prev_reg <= level_now;
            delta_reg      <= (msr_read ? 4'h0 : delta_reg) | delta_set;
        end
    end

    // read channel, one cycle after address taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            case (araddr)
                IER_OFFSET: rdata <= {24'h000000, ier_reg};
                EFR_OFFSET: rdata <= {24'h000000, efr_reg};
                MCR_OFFSET: rdata <= {24'h000000, mcr_reg};
                MSR_OFFSET:
                    rdata <= {24'h000000, level_now, delta_reg};
                STATUS_OFFSET:
                    // fifo depth stays 32 for compatible software
                    rdata <= {16'h0000, FIFO_DEPTH, 6'h00, com_select,
                              !direct_mode};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host address decode in direct mode

    logic [9:0] com_base;
    logic [1:0] irq_line;
    logic       addr_valid;

    // s1/s2 pick the range; s3 moves the line to the third pin
    always_comb begin
        case (sel_s[1:0])
            2'b00:   com_base = COM1_BASE;
            2'b01:   com_base = COM2_BASE;
            2'b10:   com_base = COM3_BASE;
            default: com_base = COM4_BASE;
        endcase
        irq_line = sel_s[2] ? 2'd2 : {1'b0, sel_s[0]};
    end

    assign addr_valid = direct_mode && !aen_n_s;

    // registered decodes; printer outputs idle high outside direct mode
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            com_select    <= 1'b0;
            lpt1_decode_n <= 1'b1;
            lpt2_decode_n <= 1'b1;
        end else begin
            com_select    <= addr_valid &&
                             addr_s[9:3] == com_base[9:3];
            lpt1_decode_n <= !(addr_valid &&
                               addr_s[9:3] == LPT1_BASE[9:3]);
            lpt2_decode_n <= !(addr_valid &&
                               addr_s[9:3] == LPT2_BASE[9:3]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pins

    logic pending;
    logic shared_mode;

    assign pending = (ier_reg[IER_RXDATA_BIT] && rx_data_avail) ||
                     (ier_reg[IER_TXEMPTY_BIT] && tx_empty) ||
                     (ier_reg[IER_RXERR_BIT] && rx_error) ||
                     (ier_reg[IER_MODEM_BIT] && |delta_reg);
    assign shared_mode = mcr_reg[MCR_SHARED_BIT];

    // shared mode drives high only when pending; others float
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            irq.out <= 3'b000;
            irq.oe  <= 3'b000;
        end else if (shared_mode) begin
            irq.out <= {2'b00, pending};
            irq.oe  <= {2'b00, pending && (!direct_mode ||
                         mcr_reg[MCR_IRQEN_BIT])};
        end else if (!direct_mode) begin
            irq.out <= {2'b00, pending};
            irq.oe  <= 3'b001;
        end else begin
            irq.out <= 3'b000;
            irq.oe  <= 3'b000;
            irq.out[irq_line] <= pending;
            irq.oe[irq_line]  <= mcr_reg[MCR_IRQEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modem control outputs and flow control

    logic rx_at_trigger;
    assign rx_at_trigger = rx_fifo_level >= rx_trigger_level;

    // auto-rts overrides only while the feature bit is set
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            rts_n       <= 1'b1;
            dtr_n       <= 1'b1;
            user_out1_n <= 1'b1;
            ps3_out     <= 1'b1;
            ps3_oe      <= 1'b0;
        end else begin
            rts_n       <= !mcr_reg[MCR_RTS_BIT] ||
                           (efr_reg[EFR_AUTO_RTS_BIT] &&
                            rx_at_trigger);
            dtr_n       <= !mcr_reg[MCR_DTR_BIT];
            user_out1_n <= !mcr_reg[MCR_OUT1_BIT];
            ps3_out     <= !mcr_reg[MCR_IRQEN_BIT];
            ps3_oe      <= !direct_mode;
        end
    end

    // halt only at a character boundary; release as soon as cts low
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            tx_halt <= 1'b0;
        end else if (!efr_reg[EFR_AUTO_CTS_BIT] || level_now[0]) begin
            tx_halt <= 1'b0;
        end else if (tx_char_done) begin
            tx_halt <= 1'b1;
        end
    end

    // serial path held off during master reset
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
        end else begin
            tx_enable <= 1'b1;
            rx_enable <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!run_n);

    sequence cts_blocked_at_boundary;
        efr_reg[EFR_AUTO_CTS_BIT] && !level_now[0] && tx_char_done;
    endsequence

    sequence cts_still_high;
        efr_reg[EFR_AUTO_CTS_BIT] && !level_now[0];
    endsequence

    AST_DIRECT_GATE: assert property (
        direct_mode && !mcr_reg[MCR_IRQEN_BIT] |=> irq.oe == 3'b000)
        else $error("direct mode interrupt driven without enable");

    AST_DIRECT_LINE: assert property (
        direct_mode && !shared_mode && mcr_reg[MCR_IRQEN_BIT] &&
        pending |=> irq.out[$past(irq_line)] && irq.oe[$past(irq_line)])
        else $error("pending interrupt not shown on selected line");

    AST_GENERIC_PUSHPULL: assert property (
        !direct_mode && !shared_mode |=> irq.oe[0] && irq.out[0] ==
        $past(pending))
        else $error("generic mode interrupt not push-pull");

    AST_SHARED_QUIET: assert property (
        shared_mode |=> irq.oe[2:1] == 2'b00)
        else $error("second or third interrupt active in shared mode");

    AST_OPEN_SOURCE: assert property (
        shared_mode && !pending |=> !irq.oe[0])
        else $error("open-source interrupt driven while idle");

    AST_DTR_FOLLOWS: assert property (
        $rose(mcr_reg[MCR_DTR_BIT]) |=> !dtr_n [*1] ##0
        $stable(mcr_reg[MCR_DTR_BIT]) or !mcr_reg[MCR_DTR_BIT])
        else $error("dtr not low after control bit set");

    AST_RTS_AUTO: assert property (
        efr_reg[EFR_AUTO_RTS_BIT] && rx_at_trigger |=> rts_n)
        else $error("rts not forced high at trigger level");

    AST_CTS_HALT: assert property (
        cts_blocked_at_boundary ##1 cts_still_high |-> tx_halt)
        else $error("transmit not halted after character with cts high");

    AST_OUT1: assert property (
        $stable(mcr_reg) [*2] |-> user_out1_n == !mcr_reg[MCR_OUT1_BIT])
        else $error("user output 1 does not follow control bit 2");

    AST_MR_DISABLE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        master_reset [*4] |=> !tx_enable && !rx_enable && rts_n && dtr_n)
        else $error("master reset did not disable serial path");

endmodule : uart_modem_host
